// file: kdsl_debounce.v
// Key debouncer: synchronises one key and emits a single press pulse.
`default_nettype none
`include "kdsl_map.vh"
module kdsl_debounce #(
  parameter DEB_TICKS = `KDSL_DEB_MS
) (
  // Clock and reset
  input  wire MCLK,
  input  wire NRST,
  // Timing
  input  wire tick,
  // Key
  input  wire key_n,
  output reg  press,
  output reg  held
);
  reg        sync1_ff;
  reg        sync2_ff;
  reg        stable_ff;
  reg [7:0]  cnt_ff;
  always @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      sync1_ff  <= 1'b0;
      sync2_ff  <= 1'b0;
      stable_ff <= 1'b0;
      cnt_ff    <= 8'h00;
      press     <= 1'b0;
      held      <= 1'b0;
    end else begin
      sync1_ff <= ~key_n;
      sync2_ff <= sync1_ff;
      press    <= 1'b0;
      // A level must stay unchanged for the whole window before it counts.
      if (sync2_ff == stable_ff) begin
        cnt_ff <= 8'h00;
      end else if (tick) begin
        if (cnt_ff == DEB_TICKS[7:0] - 8'h01) begin
          stable_ff <= sync2_ff;
          cnt_ff    <= 8'h00;
          press     <= sync2_ff;
        end else begin
          cnt_ff <= cnt_ff + 8'h01;
        end
      end
      held <= stable_ff;
    end
  end
endmodule // kdsl_debounce
`default_nettype wire

// file: kdsl_map.vh
// Constants for the keypad and display status logic.
`ifndef KDSL_MAP_VH
`define KDSL_MAP_VH
// Display modes.
`define KDSL_M_PWRUP   3'h0
`define KDSL_M_MONCODE 3'h1
`define KDSL_M_MONVAL  3'h2
`define KDSL_M_PARAM   3'h3
`define KDSL_M_SET     3'h4
`define KDSL_M_STATUS  3'h5
`define KDSL_M_FAULT   3'h6
// Save result codes shown after the confirm key.
`define KDSL_ST_SAVE_OK   3'h0
`define KDSL_ST_WPROT     3'h1
`define KDSL_ST_LOCKED    3'h2
`define KDSL_ST_RANGE     3'h3
`define KDSL_ST_RUNNING   3'h4
`define KDSL_ST_RESTART   3'h5
// Sign and byte indicator field encodings.
`define KDSL_IND_NONE  2'h0
`define KDSL_IND_LOW   2'h1
`define KDSL_IND_HIGH  2'h2
`define KDSL_IND_NEG   2'h3
// Timing, in milliseconds, and clock rate in kHz.
`define KDSL_CLK_KHZ     10000
`define KDSL_TICK_MS     1
`define KDSL_DEB_MS      20
`define KDSL_ONE_S_MS    1000
`define KDSL_TWO_S_MS    2000
`define KDSL_IDLE_MS     20000
`define KDSL_BLINK_MS    250
// Edit cursor positions and top monitor item index.
`define KDSL_DIG_LAST    3'h4
`define KDSL_MON_LAST    5'h1A
`endif

// file: kdsl_operator.sv
// Keypad operator model: presses keys with contact bounce, then lets them go.
`default_nettype none
module kdsl_operator (
  // Clock
  input  wire logic       clk,
  // Key pins, active low, pulled up while released
  output var  logic [4:0] key_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial key_n = 5'h1F;
  // Each press bounces once before it settles, so only a clean press may count.
  task automatic press(input int k, input int hold, input int post);
    @(posedge clk);
    key_n[k] <= 1'b0;
    @(posedge clk);
    key_n[k] <= 1'b1;
    @(posedge clk);
    key_n[k] <= 1'b0;
    repeat (hold) @(posedge clk);
    key_n[k] <= 1'b1;
    repeat (post) @(posedge clk);
  endtask
endmodule // kdsl_operator
`default_nettype wire

// file: kdsl_top.v
// Front panel mode, status code and edit control for a five-digit display.
// Contract
// - Show save result about one second
// - Stored value shows save-ok code
// - Write-protected parameter shows read-only code
// - Missing or wrong password shows lock code
// - Bad or out-of-range value shows range code
// - Running servo refusal shows running code
// - Restart-effective parameter shows restart code
// - Decimal 32-bit shows high/low indicator
// - Decimal negative marked in two leftmost digits
// - Hexadecimal never shows a negative sign
// - Fault shows alarm prefix and code
// - Arrows change value, shift moves blinking digit
// - Shift held two seconds toggles sign
// - Sign toggle blocked when out of range
// - Negative entry only for decimal values
// - Power-up shows monitor code one second
// - Arrows or select setting change monitor item
// - Power-up item from stored select setting
// - Twenty seconds idle with alarm: fault mode
// - Confirm in monitor toggles dec/hex
`default_nettype none
`include "kdsl_map.vh"
module kdsl_top #(
  parameter TICK_CYC  = `KDSL_CLK_KHZ * `KDSL_TICK_MS,
  parameter ONE_S     = `KDSL_ONE_S_MS / `KDSL_TICK_MS,
  parameter TWO_S     = `KDSL_TWO_S_MS / `KDSL_TICK_MS,
  parameter IDLE_T    = `KDSL_IDLE_MS / `KDSL_TICK_MS,
  parameter BLINK_T   = `KDSL_BLINK_MS / `KDSL_TICK_MS,
  parameter DEB_TICKS = `KDSL_DEB_MS / `KDSL_TICK_MS
) (
  // Clock and reset
  input  wire        MCLK,
  input  wire        NRST,
  // Keypad, active low pins
  input  wire        KEY_MODE_N,
  input  wire        KEY_SHIFT_N,
  input  wire        KEY_UP_N,
  input  wire        KEY_DOWN_N,
  input  wire        KEY_CONFIRM_N,
  // Drive fault logic
  input  wire        ALARM,
  input  wire [11:0] FAULT_CODE,
  // Parameter store, same clock domain
  input  wire [4:0]  MONITOR_SELECT_SETTING,
  input  wire        MON_SEL_WR,
  input  wire        PARAM_HEX,
  input  wire        PARAM_WIDE,
  input  wire        PARAM_WPROT,
  input  wire        PARAM_LOCKED,
  input  wire        PARAM_RUN_LOCK,
  input  wire        PARAM_RESTART,
  input  wire        SERVO_ON,
  input  wire [31:0] PARAM_VALUE,
  input  wire [31:0] PARAM_MIN,
  input  wire [31:0] PARAM_MAX,
  input  wire [31:0] MONITOR_VALUE,
  // Parameter store write
  output reg         SAVE_STB,
  output reg  [31:0] SAVE_VALUE,
  // Display content
  output reg  [2:0]  DISP_MODE,
  output reg  [2:0]  STATUS_CODE,
  output reg  [4:0]  MONITOR_ITEM,
  output reg         SHOW_HEX,
  output reg  [1:0]  SIGN_IND,
  output reg         HIGH_PART,
  output reg  [31:0] DISP_VALUE,
  output reg  [11:0] ALARM_CODE,
  output reg  [2:0]  CURSOR_DIG,
  output reg         BLINK_OFF
);
  // ------------------------------------------------------------------
  // Prescaler and key events
  // ------------------------------------------------------------------
  reg  [15:0] pre_ff;
  reg         tick_ff;
  wire [4:0]  prs;
  wire [4:0]  hld;
  always @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      pre_ff  <= 16'h0000;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= (pre_ff == TICK_CYC[15:0] - 16'h0001);
      pre_ff  <= (pre_ff == TICK_CYC[15:0] - 16'h0001) ? 16'h0000 : pre_ff + 16'h0001;
    end
  end
  kdsl_debounce #(.DEB_TICKS(DEB_TICKS)) u_k0 (.MCLK(MCLK), .NRST(NRST), .tick(tick_ff),
    .key_n(KEY_MODE_N), .press(prs[0]), .held(hld[0]));
  kdsl_debounce #(.DEB_TICKS(DEB_TICKS)) u_k1 (.MCLK(MCLK), .NRST(NRST), .tick(tick_ff),
    .key_n(KEY_SHIFT_N), .press(prs[1]), .held(hld[1]));
  kdsl_debounce #(.DEB_TICKS(DEB_TICKS)) u_k2 (.MCLK(MCLK), .NRST(NRST), .tick(tick_ff),
    .key_n(KEY_UP_N), .press(prs[2]), .held(hld[2]));
  kdsl_debounce #(.DEB_TICKS(DEB_TICKS)) u_k3 (.MCLK(MCLK), .NRST(NRST), .tick(tick_ff),
    .key_n(KEY_DOWN_N), .press(prs[3]), .held(hld[3]));
  kdsl_debounce #(.DEB_TICKS(DEB_TICKS)) u_k4 (.MCLK(MCLK), .NRST(NRST), .tick(tick_ff),
    .key_n(KEY_CONFIRM_N), .press(prs[4]), .held(hld[4]));
  wire any_key = |prs;

  // ------------------------------------------------------------------
  // Alarm synchroniser and helpers
  // ------------------------------------------------------------------
  reg alarm1_ff;
  reg alarm2_ff;
  always @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      alarm1_ff <= 1'b0;
      alarm2_ff <= 1'b0;
    end else begin
      alarm1_ff <= ALARM;
      alarm2_ff <= alarm1_ff;
    end
  end

  // Decimal step of the selected digit, 10 to the power of the position.
  function [31:0] dig_step;
    input [2:0] pos;
    begin
      case (pos)
        3'h0:    dig_step = 32'h00000001;
        3'h1:    dig_step = 32'h0000000A;
        3'h2:    dig_step = 32'h00000064;
        3'h3:    dig_step = 32'h000003E8;
        default: dig_step = 32'h00002710;
      endcase
    end
  endfunction

  function in_range;
    input [31:0] v;
    input [31:0] lo;
    input [31:0] hi;
    begin
      in_range = ($signed(v) >= $signed(lo)) && ($signed(v) <= $signed(hi));
    end
  endfunction

  // ------------------------------------------------------------------
  // Mode machine
  // ------------------------------------------------------------------
  reg [2:0]  mode_ff;
  reg [2:0]  back_ff;
  reg [14:0] tmr_ff;
  reg [14:0] idle_ff;
  reg [11:0] shold_ff;
  reg        sdone_ff;
  reg [7:0]  blk_ff;
  reg [31:0] edit_ff;
  reg        alarm_old_ff;
  reg [2:0]  nxt_mode;
  wire [31:0] step = PARAM_HEX ? (32'h00000001 << {CURSOR_DIG, 2'b00}) : dig_step(CURSOR_DIG);
  wire [31:0] negv = 32'h00000000 - edit_ff;
  wire        alarm_rise = alarm2_ff & ~alarm_old_ff;
  wire        fault_go   = (mode_ff != `KDSL_M_FAULT) && (mode_ff != `KDSL_M_PWRUP) &&
                           (mode_ff != `KDSL_M_MONCODE) &&
                           (alarm_rise || (alarm2_ff && idle_ff == IDLE_T[14:0]));
  wire        one_s_up   = tick_ff && (tmr_ff == ONE_S[14:0] - 15'h0001);

  // Next display mode; a fault entry overrides whatever key came in the same cycle.
  always @* begin
    nxt_mode = mode_ff;
    case (mode_ff)
      `KDSL_M_PWRUP: begin
        nxt_mode = `KDSL_M_MONCODE;
      end
      `KDSL_M_MONCODE: begin
        if (one_s_up) nxt_mode = `KDSL_M_MONVAL;
      end
      `KDSL_M_MONVAL: begin
        if (prs[2] | prs[3]) nxt_mode = `KDSL_M_MONCODE;
        if (prs[0]) nxt_mode = `KDSL_M_PARAM;
      end
      `KDSL_M_PARAM: begin
        if (prs[0]) nxt_mode = `KDSL_M_MONVAL;
        if (prs[4]) nxt_mode = `KDSL_M_SET;
      end
      `KDSL_M_SET: begin
        if (prs[0]) nxt_mode = `KDSL_M_PARAM;
        if (prs[4]) nxt_mode = `KDSL_M_STATUS;
      end
      `KDSL_M_STATUS: begin
        if (one_s_up) nxt_mode = `KDSL_M_PARAM;
      end
      `KDSL_M_FAULT: begin
        if (prs[0]) nxt_mode = back_ff;
      end
      default: nxt_mode = `KDSL_M_PWRUP;
    endcase
    if (fault_go) nxt_mode = `KDSL_M_FAULT;
  end

  always @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      mode_ff      <= `KDSL_M_PWRUP;
      back_ff      <= `KDSL_M_PARAM;
      tmr_ff       <= 15'h0000;
      idle_ff      <= 15'h0000;
      shold_ff     <= 12'h000;
      sdone_ff     <= 1'b0;
      blk_ff       <= 8'h00;
      edit_ff      <= 32'h00000000;
      alarm_old_ff <= 1'b0;
      SAVE_STB     <= 1'b0;
      SAVE_VALUE   <= 32'h00000000;
      STATUS_CODE  <= `KDSL_ST_SAVE_OK;
      MONITOR_ITEM <= 5'h00;
      SHOW_HEX     <= 1'b0;
      CURSOR_DIG   <= 3'h0;
      BLINK_OFF    <= 1'b0;
    end else begin
      alarm_old_ff <= alarm2_ff;
      SAVE_STB     <= 1'b0;
      if (tick_ff) begin
        tmr_ff <= tmr_ff + 15'h0001;
        if (idle_ff != IDLE_T[14:0]) idle_ff <= idle_ff + 15'h0001;
        blk_ff <= (blk_ff == BLINK_T[7:0] - 8'h01) ? 8'h00 : blk_ff + 8'h01;
        if (blk_ff == BLINK_T[7:0] - 8'h01) BLINK_OFF <= ~BLINK_OFF;
      end
      if (any_key) idle_ff <= 15'h0000;
      if (MON_SEL_WR) MONITOR_ITEM <= MONITOR_SELECT_SETTING;
      case (mode_ff)
        `KDSL_M_PWRUP: begin
          MONITOR_ITEM <= MONITOR_SELECT_SETTING;
          tmr_ff       <= 15'h0000;
        end
        `KDSL_M_MONVAL: begin
          if (prs[4]) SHOW_HEX <= ~SHOW_HEX;
          if (prs[2] | prs[3]) begin
            if (prs[2])
              MONITOR_ITEM <= (MONITOR_ITEM == `KDSL_MON_LAST) ? 5'h00 : MONITOR_ITEM + 5'h01;
            else
              MONITOR_ITEM <= (MONITOR_ITEM == 5'h00) ? `KDSL_MON_LAST : MONITOR_ITEM - 5'h01;
            tmr_ff   <= 15'h0000;
          end
        end
        `KDSL_M_PARAM: begin
          if (prs[4]) begin
            edit_ff    <= PARAM_VALUE;
            CURSOR_DIG <= 3'h0;
          end
        end
        `KDSL_M_SET: begin
          if (prs[2]) edit_ff <= edit_ff + step;
          if (prs[3]) edit_ff <= edit_ff - step;
          if (prs[1]) begin
            CURSOR_DIG <= (CURSOR_DIG == `KDSL_DIG_LAST) ? 3'h0 : CURSOR_DIG + 3'h1;
            shold_ff   <= 12'h000;
            sdone_ff   <= 1'b0;
          end else if (hld[1] && tick_ff && !sdone_ff) begin
            shold_ff <= shold_ff + 12'h001;
            if (shold_ff == TWO_S[11:0] - 12'h001) begin
              sdone_ff <= 1'b1;
              // Hex values are always positive, and the flip must stay in range.
              if (!PARAM_HEX && in_range(negv, PARAM_MIN, PARAM_MAX))
                edit_ff <= negv;
            end
          end
          if (prs[4]) begin
            tmr_ff <= 15'h0000;
            // Refusal priority: protection, then password, then running, then range.
            if (PARAM_WPROT)
              STATUS_CODE <= `KDSL_ST_WPROT;
            else if (PARAM_LOCKED)
              STATUS_CODE <= `KDSL_ST_LOCKED;
            else if (PARAM_RUN_LOCK && SERVO_ON)
              STATUS_CODE <= `KDSL_ST_RUNNING;
            else if (!in_range(edit_ff, PARAM_MIN, PARAM_MAX))
              STATUS_CODE <= `KDSL_ST_RANGE;
            else begin
              SAVE_STB    <= 1'b1;
              SAVE_VALUE  <= edit_ff;
              STATUS_CODE <= PARAM_RESTART ? `KDSL_ST_RESTART : `KDSL_ST_SAVE_OK;
            end
          end
        end
        default: begin
        end
      endcase
      if (fault_go) begin
        back_ff <= mode_ff;
        idle_ff <= 15'h0000;
      end
      if (mode_ff == `KDSL_M_FAULT && prs[0]) idle_ff <= 15'h0000;
      mode_ff <= nxt_mode;
    end
  end

  // ------------------------------------------------------------------
  // Display content
  // ------------------------------------------------------------------
  reg [31:0] src;
  reg        wide;
  reg        hex;
  always @* begin
    src  = (mode_ff == `KDSL_M_SET) ? edit_ff :
           (mode_ff == `KDSL_M_PARAM) ? PARAM_VALUE : MONITOR_VALUE;
    wide = (mode_ff == `KDSL_M_MONVAL) ? 1'b1 : PARAM_WIDE;
    hex  = (mode_ff == `KDSL_M_MONVAL) ? SHOW_HEX : PARAM_HEX;
  end

  always @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      DISP_MODE  <= `KDSL_M_PWRUP;
      SIGN_IND   <= `KDSL_IND_NONE;
      HIGH_PART  <= 1'b0;
      DISP_VALUE <= 32'h00000000;
      ALARM_CODE <= 12'h000;
    end else begin
      DISP_MODE  <= mode_ff;
      ALARM_CODE <= FAULT_CODE;
      HIGH_PART  <= hld[2] & hld[3];
      if (!hex && (wide ? src[31] : src[15])) begin
        SIGN_IND   <= `KDSL_IND_NEG;
        DISP_VALUE <= wide ? 32'h00000000 - src : {16'h0000, 16'h0000 - src[15:0]};
      end else begin
        // Hex display never carries a sign.
        SIGN_IND   <= (!hex && wide) ? ((hld[2] & hld[3]) ? `KDSL_IND_HIGH : `KDSL_IND_LOW)
                                     : `KDSL_IND_NONE;
        DISP_VALUE <= wide ? src : {16'h0000, src[15:0]};
      end
    end
  end
endmodule // kdsl_top
`default_nettype wire

// file: kdsl_top_props.sv
// Concurrent checks on the front panel control ports.
`default_nettype none
module kdsl_chk (
  // Clock and reset
  input wire logic        MCLK,
  input wire logic        NRST,
  // Inputs
  input wire logic        ALARM,
  input wire logic [11:0] FAULT_CODE,
  input wire logic [4:0]  MONITOR_SELECT_SETTING,
  input wire logic        MON_SEL_WR,
  input wire logic        PARAM_HEX,
  input wire logic        PARAM_WPROT,
  input wire logic        PARAM_LOCKED,
  input wire logic        PARAM_RUN_LOCK,
  input wire logic        SERVO_ON,
  input wire logic [31:0] PARAM_MIN,
  input wire logic [31:0] PARAM_MAX,
  // Outputs
  input wire logic        SAVE_STB,
  input wire logic [31:0] SAVE_VALUE,
  input wire logic [2:0]  DISP_MODE,
  input wire logic [2:0]  STATUS_CODE,
  input wire logic [4:0]  MONITOR_ITEM,
  input wire logic        SHOW_HEX,
  input wire logic [1:0]  SIGN_IND,
  input wire logic [11:0] ALARM_CODE,
  input wire logic [2:0]  CURSOR_DIG
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!NRST);
  sequence s_save;
    SAVE_STB;
  endsequence
  // The result stays up for a while and then hands back to parameter mode.
  sequence s_status_show;
    ##1 (DISP_MODE == 3'h5) [*8] ##[1:30] DISP_MODE == 3'h3;
  endsequence
  a_save_shows_status: assert property (s_save |-> s_status_show)
    else $error("save not followed by status display");
  a_save_ok_code: assert property (s_save |-> STATUS_CODE inside {3'h0, 3'h5})
    else $error("stored value with wrong status code");
  a_refused_no_save: assert property (s_save |-> !($past(PARAM_WPROT) || $past(PARAM_LOCKED)
    || ($past(PARAM_RUN_LOCK) && $past(SERVO_ON))))
    else $error("refused write produced a save");
  a_save_in_range: assert property (s_save |-> $signed(SAVE_VALUE) >= $signed(PARAM_MIN)
    && $signed(SAVE_VALUE) <= $signed(PARAM_MAX))
    else $error("out of range value saved");
  a_hex_never_neg: assert property (($past(SHOW_HEX) && DISP_MODE == 3'h2) || (DISP_MODE == 3'h4
    && PARAM_HEX && $past(PARAM_HEX, 4)) |-> SIGN_IND != 2'h3)
    else $error("negative sign in hex display");
  a_fault_code_shown: assert property (DISP_MODE == 3'h6 |-> ALARM_CODE == $past(FAULT_CODE))
    else $error("fault code not shown");
  a_alarm_to_fault: assert property ($rose(ALARM) && DISP_MODE inside {[3'h2:3'h5]}
    |-> ##[1:6] DISP_MODE == 3'h6)
    else $error("alarm did not enter fault display");
  a_powerup_item: assert property (DISP_MODE == 3'h1 && $past(DISP_MODE) == 3'h0
    |-> MONITOR_ITEM == MONITOR_SELECT_SETTING ##1 (DISP_MODE == 3'h1) [*8])
    else $error("power-up monitor code wrong");
  a_select_loads: assert property (MON_SEL_WR |=> MONITOR_ITEM == $past(MONITOR_SELECT_SETTING))
    else $error("monitor select not loaded");
  a_hex_toggle_mon: assert property ($changed(SHOW_HEX) |-> $past(DISP_MODE) == 3'h2)
    else $error("format toggled outside monitor mode");
  a_cursor_bound: assert property (CURSOR_DIG <= 3'h4)
    else $error("cursor beyond last digit");
endmodule // kdsl_chk
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the front panel control block.
`default_nettype none
`include "kdsl_map.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, nrst, alarm, wr, p_hex, p_wide, p_wp, p_lk, p_run, p_rs, servo;
  logic        stb, shex, hpart, blink, b;
  logic [4:0]  key_n, sel, item;
  logic [11:0] fc, acode;
  logic [31:0] p_val, p_min, p_max, sval, stb_val, v, dval, mv;
  logic [2:0]  mode, scode, cur, e;
  logic [1:0]  sign;
  int          seed = 78;
  int          bad_count = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          stb_n = 0;
  int          n;
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  kdsl_operator u_op (.clk(mclk), .key_n(key_n));
  kdsl_top #(.TICK_CYC(4), .ONE_S(5), .TWO_S(8), .IDLE_T(20), .BLINK_T(2), .DEB_TICKS(2)) u_dut (
    .MCLK(mclk), .NRST(nrst), .KEY_MODE_N(key_n[0]), .KEY_SHIFT_N(key_n[1]),
    .KEY_UP_N(key_n[2]), .KEY_DOWN_N(key_n[3]), .KEY_CONFIRM_N(key_n[4]), .ALARM(alarm),
    .FAULT_CODE(fc), .MONITOR_SELECT_SETTING(sel), .MON_SEL_WR(wr), .PARAM_HEX(p_hex),
    .PARAM_WIDE(p_wide), .PARAM_WPROT(p_wp), .PARAM_LOCKED(p_lk), .PARAM_RUN_LOCK(p_run),
    .PARAM_RESTART(p_rs), .SERVO_ON(servo), .PARAM_VALUE(p_val), .PARAM_MIN(p_min),
    .PARAM_MAX(p_max), .MONITOR_VALUE(mv), .SAVE_STB(stb), .SAVE_VALUE(sval), .DISP_MODE(mode),
    .STATUS_CODE(scode), .MONITOR_ITEM(item), .SHOW_HEX(shex), .SIGN_IND(sign),
    .HIGH_PART(hpart), .DISP_VALUE(dval), .ALARM_CODE(acode), .CURSOR_DIG(cur),
    .BLINK_OFF(blink));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic ok, input string what);
    n_checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("MISMATCH at %0t: %s", $time, what);
    end
  endtask
  task automatic wait_mode(input logic [2:0] m);
    int k;
    k = 0;
    do begin
      @(negedge mclk);
      k++;
    end while (mode !== m && k < 400);
  endtask
  // Refusal priority: protection, then password, then running servo, then range.
  function automatic logic [2:0] exp_code(input logic wp, lk, rl, so, rng, rs);
    if (wp) return `KDSL_ST_WPROT;
    if (lk) return `KDSL_ST_LOCKED;
    if (rl && so) return `KDSL_ST_RUNNING;
    if (!rng) return `KDSL_ST_RANGE;
    return rs ? `KDSL_ST_RESTART : `KDSL_ST_SAVE_OK;
  endfunction
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (stb === 1'b1) begin
      stb_n <= stb_n + 1;
      stb_val <= sval;
    end
    if (cyc == 30000) begin
      bad_count++;
      report_and_stop;
    end
  end
  initial begin
    {nrst, alarm, wr, p_hex, p_wp, p_lk, p_run, p_rs, servo} = '0;
    p_wide = 1'($random(seed));
    sel = 5'($unsigned($random(seed)) % 27);
    {fc, p_val, p_min, p_max, v, mv} = '0;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    wait_mode(3'h1);
    check(mode === 3'h1 && item === sel, "power-up code");
    wait_mode(3'h2);
    check(mode === 3'h2, "monitor mode");
    $display("test power-up done");
    u_op.press(2, 20, 24);
    wait_mode(3'h2);
    check(item === ((sel == 5'h1A) ? 5'h00 : sel + 5'h01), "up step");
    @(posedge mclk);
    mv <= {1'b1, 31'($random(seed))};
    for (int i = 0; i < 2; i++) begin
      u_op.press(4, 20, 24);
      check(shex === 1'(i == 0), "format toggle");
      check(dval === ((i == 0) ? mv : -mv) && hpart === 1'b0, "monitor value");
      check(sign === ((i == 0) ? 2'h0 : 2'h3), "monitor sign");
    end
    @(posedge mclk);
    sel <= 5'($unsigned($random(seed)) % 27);
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    @(negedge mclk);
    check(item === sel, "select load");
    b = blink;
    repeat (8) @(negedge mclk);
    check(blink === ~b, "blink period");
    $display("test monitor done");
    u_op.press(0, 20, 24);
    wait_mode(3'h3);
    for (int i = 0; i < 9; i++) begin
      @(posedge mclk);
      v = $unsigned($random(seed)) % 900 + 1;
      p_wp <= (i == 1);
      p_lk <= (i == 2);
      p_run <= (i == 4);
      servo <= (i == 4) || (i == 0);
      p_rs <= (i == 5);
      p_hex <= (i == 8);
      p_min <= (i == 7) ? 32'h0 : -32'sd1000;
      p_max <= (i == 3) ? 32'd1000 : 32'd1000 + 32'($unsigned($random(seed)) % 50);
      p_wide <= 1'($random(seed));
      p_val <= (i == 3) ? 32'd1005 : v;
      u_op.press(4, 20, 24);
      check(mode === 3'h4, "setting entry");
      check(dval === p_val, "setting value");
      check(sign === ((p_hex || !p_wide) ? 2'h0 : 2'h1), "byte indicator");
      if (i == 0) u_op.press(2, 20, 24);
      if (i > 5) begin
        u_op.press(1, 60, 24);
        check((sign === 2'h3) === (i == 6), "sign toggle");
        check(cur === 3'h1, "cursor move");
      end
      n = stb_n;
      u_op.press(4, 12, 0);
      wait_mode(3'h5);
      e = exp_code(i == 1, i == 2, i == 4, i == 4 || i == 0, i != 3, i == 5);
      check(scode === e, "status code");
      check((stb_n != n) === (e == 3'h0 || e == 3'h5), "save strobe");
      if (stb_n != n)
        check(stb_val === ((i == 6) ? -v : v + 32'(i == 0)), "saved value");
      wait_mode(3'h3);
      check(mode === 3'h3, "back to param");
    end
    $display("test save results done");
    @(posedge mclk);
    fc <= 12'($random(seed));
    repeat (3) @(posedge mclk);
    alarm <= 1'b1;
    wait_mode(3'h6);
    check(mode === 3'h6 && acode === fc, "fault display");
    u_op.press(0, 20, 24);
    check(mode !== 3'h6, "fault left");
    wait_mode(3'h6);
    check(mode === 3'h6, "idle return");
    $display("test fault done");
    report_and_stop;
  end
endmodule // testbench
bind kdsl_top kdsl_chk u_chk (.MCLK(MCLK), .NRST(NRST), .ALARM(ALARM), .FAULT_CODE(FAULT_CODE),
  .MONITOR_SELECT_SETTING(MONITOR_SELECT_SETTING), .MON_SEL_WR(MON_SEL_WR),
  .PARAM_HEX(PARAM_HEX), .PARAM_WPROT(PARAM_WPROT), .PARAM_LOCKED(PARAM_LOCKED),
  .PARAM_RUN_LOCK(PARAM_RUN_LOCK), .SERVO_ON(SERVO_ON), .PARAM_MIN(PARAM_MIN),
  .PARAM_MAX(PARAM_MAX), .SAVE_STB(SAVE_STB), .SAVE_VALUE(SAVE_VALUE), .DISP_MODE(DISP_MODE),
  .STATUS_CODE(STATUS_CODE), .MONITOR_ITEM(MONITOR_ITEM), .SHOW_HEX(SHOW_HEX),
  .SIGN_IND(SIGN_IND), .ALARM_CODE(ALARM_CODE), .CURSOR_DIG(CURSOR_DIG));
`default_nettype wire
